// *** inc/aac_pkg.sv ***
/*
 * Constants, field layouts and carrier types of the arc alarm channel logic.
 * Assumes a 50 MHz system clock and 32-bit APB register access.
 */
package aac_pkg;
    localparam int NUM_CH   = 16;
    localparam int NUM_GRP  = 4;
    localparam int NUM_CELL = NUM_CH + NUM_GRP;
    localparam int NUM_PAIR = NUM_CH / 2;
    localparam int MV_W     = 10;
    localparam int PER_W    = 15;
    localparam int IDX_W    = 5;
    localparam int TICK_W   = 16;
    localparam int BOOT_W   = 24;

    localparam int CLK_NS      = 20;
    localparam int TICK_NS     = 100000;
    localparam int TICK_CYCLES = TICK_NS / CLK_NS;
    localparam int BOOT_US     = 2000;
    localparam int BOOT_CYCLES = BOOT_US * 1000 / CLK_NS;

    // Auto-reset period in 0.1 ms ticks, threshold in mV
    localparam logic [PER_W-1:0] PER_MIN = 15'h0001;
    localparam logic [PER_W-1:0] PER_MAX = 15'h4E20;
    localparam logic [MV_W-1:0]  THR_MIN = 10'h014;
    localparam logic [MV_W-1:0]  THR_MAX = 10'h1F4;

    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_ACK    = 8'h04;
    localparam logic [7:0] OFS_THRESH = 8'h08;
    localparam logic [7:0] OFS_SEL    = 8'h0C;
    localparam logic [7:0] OFS_CFG    = 8'h10;
    localparam logic [7:0] OFS_GRP    = 8'h14;

    localparam int ST_BOOT_BIT  = 20;
    localparam int ACK_ALL_BIT  = 31;
    localparam int CFG_POL_BIT  = 0;
    localparam int CFG_AUTO_BIT = 1;
    localparam int CFG_PER_LSB  = 16;
    localparam int GRP_PAIR_LSB = 16;

    typedef struct packed {
        logic             polNormal;
        logic             autoEn;
        logic [PER_W-1:0] period;
    } aac_cfg_s;

    typedef struct packed {
        logic [NUM_PAIR-1:0] andPairs;
        logic [NUM_CH-1:0]   members;
    } aac_grp_s;

    typedef struct packed {
        logic powerFail;
        logic cpuErr;
        logic cardErr;
        logic resetBtn;
        logic remoteTest;
        logic remoteReset;
    } aac_pins_s;

    localparam aac_cfg_s CFG_RESET = '{polNormal: 1'b0, autoEn: 1'b0, period: PER_MIN};
    localparam aac_grp_s GRP_RESET = '{andPairs: '0, members: '1};
endpackage

// *** verilog/aac_alarm_cell.sv ***
/*
 * One latched arc alarm with its auto-reset timer, used per channel and per group.
 * Assumes tick is a one-cycle pulse every 0.1 ms on the same clock.
 */
module aac_alarm_cell
    import aac_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     rstn,
    input  wire logic     arcIn,
    input  wire logic     ack,
    input  wire logic     tick,
    input  wire aac_cfg_s cfg,
    output logic          alarm
);
    logic             alarm_reg;
    logic             alarm_next;
    logic [PER_W-1:0] cnt_reg;
    logic [PER_W-1:0] cnt_next;

    always_comb begin
        alarm_next = alarm_reg;
        cnt_next   = cnt_reg;
        if (arcIn) begin
            // Set beats any clear arriving in the same cycle
            alarm_next = 1'b1;
            cnt_next   = '0;
        end else if (ack) begin
            alarm_next = 1'b0;
            cnt_next   = '0;
        end else if (alarm_reg && cfg.autoEn) begin
            if (cnt_reg >= cfg.period) begin
                alarm_next = 1'b0;
                cnt_next   = '0;
            end else if (tick) begin
                cnt_next = cnt_reg + PER_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            alarm_reg <= 1'b0;
            cnt_reg   <= '0;
        end else begin
            alarm_reg <= alarm_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign alarm = alarm_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence arcSeen;
        arcIn;
    endsequence

    sequence quietExpired;
        alarm_reg && cfg.autoEn && !arcIn && !ack && cnt_reg >= cfg.period;
    endsequence

    hold_manual_a: assert property (alarm_reg && !cfg.autoEn && !arcIn && !ack |=> alarm_reg)
        else $error("alarm cleared without acknowledge");
    light_keeps_a: assert property (arcSeen |=> alarm_reg && cnt_reg == '0)
        else $error("alarm or timer not set by arc");
    auto_clear_a: assert property (quietExpired |=> !alarm_reg)
        else $error("auto-reset did not clear alarm");
    timer_step_a: assert property (alarm_reg && cfg.autoEn && !arcIn && !ack && tick
                                   && cnt_reg < cfg.period |=> cnt_reg == $past(cnt_reg) + 1)
        else $error("auto-reset timer did not advance on tick");
endmodule

// *** verilog/aac_alarm_logic.sv ***
/*
 * Arc alarm logic for sixteen detector channels and four combining groups,
 * with polarity-selectable outputs, relays and an APB register slave.
 * Assumes pdMv and keypad strobes come from logic on clk; pins are synchronised here.
 */
// Added by the designer: the APB slave port and the address map.
// Function
// - normal polarity: output low idle, high alarm
// - inverted polarity default: output high idle, low alarm
// - open collector follows the same polarity choice
// - auto-reset clears alarm after period without arc
// - without auto-reset alarm holds until acknowledged
// - auto-reset period 0.1 to 2000 ms, default 0.1
// - arc when detector voltage reaches the threshold
// - OR mode: any member alarm asserts group
// - AND mode: pair term needs both alarms
// - polarity and auto-reset held per channel and group
// - after reset all groups OR all sixteen channels
// - keypad writes polarity, auto-reset and group logic
// - period and threshold only via configuration bus
// - system OK relay closed only when healthy
// - arc relay closed on alarm, card error, boot
// - reset button or bus command acknowledges alarms
// - after boot self-test all alarms idle, ready
// - every module gives a power-failure open collector
// - remote test and reset inputs are accepted
// - button acknowledges alarm unless light persists
// - global reset acknowledges every alarm at once; alarms whose arc or group term is still true that cycle stay set
module aac_alarm_logic
    import aac_pkg::*;
#(
    parameter int TICK_CNT = TICK_CYCLES,
    parameter int BOOT_CNT = BOOT_CYCLES
) (
    input  wire logic                          clk,
    input  wire logic                          rstn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [NUM_CH-1:0][MV_W-1:0]   pdMv,
    input  wire logic [NUM_CELL-1:0]           btnPin,
    input  wire aac_pins_s                     pins,
    input  wire logic                          kpWe,
    input  wire logic [IDX_W-1:0]              kpIndex,
    input  wire logic                          kpPolNormal,
    input  wire logic                          kpAutoEn,
    input  wire logic                          kpGrpWe,
    input  wire logic [1:0]                    kpGrpIdx,
    input  wire aac_grp_s                      kpGrp,
    output logic      [NUM_CELL-1:0]           arcTtl,
    output logic      [NUM_CELL-1:0]           ocOn,
    output logic      [NUM_CELL-1:0]           pfOcOn,
    output logic                               sysOkClosed,
    output logic                               arcRelayClosed,
    output logic                               ready
);
    function automatic logic grp_term(aac_grp_s g, logic [NUM_CH-1:0] a);
        logic t;
        t = 1'b0;
        for (int p = 0; p < NUM_PAIR; p++) begin
            if (g.andPairs[p])
                t |= g.members[2*p] & g.members[2*p+1] & a[2*p] & a[2*p+1];
            else
                t |= (g.members[2*p] & a[2*p]) | (g.members[2*p+1] & a[2*p+1]);
        end
        return t;
    endfunction

    function automatic logic [PER_W-1:0] clamp_per(logic [31:0] v);
        logic [PER_W-1:0] r;
        r = v[PER_W-1:0];
        if (v < 32'(PER_MIN))
            r = PER_MIN;
        else if (v > 32'(PER_MAX))
            r = PER_MAX;
        return r;
    endfunction

    function automatic logic [MV_W-1:0] clamp_thr(logic [31:0] v);
        logic [MV_W-1:0] r;
        r = v[MV_W-1:0];
        if (v < 32'(THR_MIN))
            r = THR_MIN;
        else if (v > 32'(THR_MAX))
            r = THR_MAX;
        return r;
    endfunction

    // Pin synchronisers; levels come from the second stage, edges from it and its delayed copy
    aac_pins_s             pinS1_reg;
    aac_pins_s             pinS2_reg;
    aac_pins_s             pinPrev_reg;
    logic [NUM_CELL-1:0]   btnS1_reg;
    logic [NUM_CELL-1:0]   btnS2_reg;
    logic [NUM_CELL-1:0]   btnPrev_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinS1_reg   <= '0;
            pinS2_reg   <= '0;
            pinPrev_reg <= '0;
            btnS1_reg   <= '0;
            btnS2_reg   <= '0;
            btnPrev_reg <= '0;
        end else begin
            pinS1_reg   <= pins;
            pinS2_reg   <= pinS1_reg;
            pinPrev_reg <= pinS2_reg;
            btnS1_reg   <= btnPin;
            btnS2_reg   <= btnS1_reg;
            btnPrev_reg <= btnS2_reg;
        end
    end

    logic [NUM_CELL-1:0] btnEdge;
    logic                globalAck;
    logic                remoteTestEdge;
    logic                apbWr;
    logic                apbAckAll;
    logic [NUM_CELL-1:0] apbAckVec;

    assign btnEdge        = btnS2_reg & ~btnPrev_reg;
    assign remoteTestEdge = pinS2_reg.remoteTest & ~pinPrev_reg.remoteTest;
    assign apbWr          = psel & penable & pready & pwrite;
    assign apbAckAll      = apbWr && paddr == OFS_ACK && pwdata[ACK_ALL_BIT];
    assign apbAckVec      = (apbWr && paddr == OFS_ACK) ? pwdata[NUM_CELL-1:0] : '0;
    assign globalAck      = (pinS2_reg.resetBtn & ~pinPrev_reg.resetBtn)
                          | (pinS2_reg.remoteReset & ~pinPrev_reg.remoteReset)
                          | apbAckAll;

    // Time base and boot sequence
    logic [TICK_W-1:0] tickCnt_reg;
    logic [TICK_W-1:0] tickCnt_next;
    logic              tick_reg;
    logic              tick_next;
    logic [BOOT_W-1:0] bootCnt_reg;
    logic [BOOT_W-1:0] bootCnt_next;
    logic              booted_reg;
    logic              booted_next;

    always_comb begin
        tickCnt_next = tickCnt_reg + TICK_W'(1);
        tick_next    = 1'b0;
        if (tickCnt_reg == TICK_W'(TICK_CNT - 1)) begin
            tickCnt_next = '0;
            tick_next    = 1'b1;
        end
        bootCnt_next = bootCnt_reg;
        booted_next  = booted_reg;
        if (!booted_reg) begin
            bootCnt_next = bootCnt_reg + BOOT_W'(1);
            booted_next  = bootCnt_reg == BOOT_W'(BOOT_CNT - 1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tickCnt_reg <= '0;
            tick_reg    <= 1'b0;
            bootCnt_reg <= '0;
            booted_reg  <= 1'b0;
        end else begin
            tickCnt_reg <= tickCnt_next;
            tick_reg    <= tick_next;
            bootCnt_reg <= bootCnt_next;
            booted_reg  <= booted_next;
        end
    end

    // Configuration
    aac_cfg_s [NUM_CELL-1:0] cfg_reg;
    aac_cfg_s [NUM_CELL-1:0] cfg_next;
    aac_grp_s [NUM_GRP-1:0]  grp_reg;
    aac_grp_s [NUM_GRP-1:0]  grp_next;
    logic [MV_W-1:0]         thr_reg;
    logic [MV_W-1:0]         thr_next;
    logic [IDX_W-1:0]        sel_reg;
    logic [IDX_W-1:0]        sel_next;

    always_comb begin
        cfg_next = cfg_reg;
        grp_next = grp_reg;
        thr_next = thr_reg;
        sel_next = sel_reg;
        // Keypad cannot reach period or threshold
        if (kpWe && kpIndex < IDX_W'(NUM_CELL)) begin
            cfg_next[kpIndex].polNormal = kpPolNormal;
            cfg_next[kpIndex].autoEn    = kpAutoEn;
        end
        if (kpGrpWe)
            grp_next[kpGrpIdx] = kpGrp;
        if (apbWr) begin
            if (paddr == OFS_THRESH)
                thr_next = clamp_thr(pwdata);
            if (paddr == OFS_SEL && pwdata < 32'(NUM_CELL))
                sel_next = pwdata[IDX_W-1:0];
            if (paddr == OFS_CFG) begin
                cfg_next[sel_reg].polNormal = pwdata[CFG_POL_BIT];
                cfg_next[sel_reg].autoEn    = pwdata[CFG_AUTO_BIT];
                cfg_next[sel_reg].period    = clamp_per(32'(pwdata[31:CFG_PER_LSB]));
            end
            for (int k = 0; k < NUM_GRP; k++) begin
                if (paddr == OFS_GRP + 8'(4 * k)) begin
                    grp_next[k].members  = pwdata[NUM_CH-1:0];
                    grp_next[k].andPairs = pwdata[GRP_PAIR_LSB +: NUM_PAIR];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_reg <= {NUM_CELL{CFG_RESET}};
            grp_reg <= {NUM_GRP{GRP_RESET}};
            thr_reg <= THR_MIN;
            sel_reg <= '0;
        end else begin
            cfg_reg <= cfg_next;
            grp_reg <= grp_next;
            thr_reg <= thr_next;
            sel_reg <= sel_next;
        end
    end

    // Alarm cells: channels first, then groups
    logic [NUM_CELL-1:0] alarmVec;
    logic [NUM_CELL-1:0] arcVec;
    logic [NUM_CELL-1:0] ackVec;
    logic [NUM_CELL-1:0] polVec;

    // Arcs are ignored until boot completes so every alarm starts idle
    for (genvar i = 0; i < NUM_CELL; i++) begin : g_cell
        logic hit;
        if (i < NUM_CH) begin : g_ch
            assign hit = (pdMv[i] >= thr_reg) | remoteTestEdge;
        end else begin : g_grp
            assign hit = grp_term(grp_reg[i-NUM_CH], alarmVec[NUM_CH-1:0]);
        end
        assign arcVec[i] = booted_reg & (hit | (btnEdge[i] & ~alarmVec[i]));
        assign ackVec[i] = ~booted_reg | globalAck | apbAckVec[i]
                         | (btnEdge[i] & alarmVec[i]);
        assign polVec[i] = cfg_reg[i].polNormal;

        aac_alarm_cell u_cell (
            .clk   (clk),
            .rstn  (rstn),
            .arcIn (arcVec[i]),
            .ack   (ackVec[i]),
            .tick  (tick_reg),
            .cfg   (cfg_reg[i]),
            .alarm (alarmVec[i])
        );
    end

    // Registered outputs
    logic [NUM_CELL-1:0] ttl_next;
    logic [NUM_CELL-1:0] pf_next;
    logic                sysOk_next;
    logic                arcRel_next;

    always_comb begin
        ttl_next    = alarmVec ^ ~polVec;
        pf_next     = {NUM_CELL{pinS2_reg.powerFail}};
        sysOk_next  = booted_reg & ~pinS2_reg.powerFail & ~pinS2_reg.cpuErr
                    & ~pinS2_reg.cardErr;
        arcRel_next = ~booted_reg | (|alarmVec) | pinS2_reg.cardErr;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            arcTtl         <= '1;
            ocOn           <= '1;
            pfOcOn         <= '0;
            sysOkClosed    <= 1'b0;
            arcRelayClosed <= 1'b1;
            ready          <= 1'b0;
        end else begin
            arcTtl         <= ttl_next;
            ocOn           <= ttl_next;
            pfOcOn         <= pf_next;
            sysOkClosed    <= sysOk_next;
            arcRelayClosed <= arcRel_next;
            ready          <= booted_reg;
        end
    end

    // APB slave: one wait-free access phase, ready raised from the setup cycle
    logic [31:0] rd_next;
    logic        err_next;
    logic        rdy_next;

    always_comb begin
        rd_next  = '0;
        err_next = 1'b0;
        rdy_next = psel & ~penable;
        unique case (paddr)
            OFS_STATUS: begin
                rd_next[NUM_CELL-1:0] = alarmVec;
                rd_next[ST_BOOT_BIT]  = booted_reg;
            end
            OFS_ACK: rd_next = '0;
            OFS_THRESH: rd_next[MV_W-1:0] = thr_reg;
            OFS_SEL: rd_next[IDX_W-1:0] = sel_reg;
            OFS_CFG: begin
                rd_next[CFG_POL_BIT]             = cfg_reg[sel_reg].polNormal;
                rd_next[CFG_AUTO_BIT]            = cfg_reg[sel_reg].autoEn;
                rd_next[CFG_PER_LSB +: PER_W]    = cfg_reg[sel_reg].period;
            end
            default: err_next = 1'b1;
        endcase
        for (int k = 0; k < NUM_GRP; k++) begin
            if (paddr == OFS_GRP + 8'(4 * k)) begin
                err_next                          = 1'b0;
                rd_next[NUM_CH-1:0]               = grp_reg[k].members;
                rd_next[GRP_PAIR_LSB +: NUM_PAIR] = grp_reg[k].andPairs;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata  <= '0;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else begin
            prdata  <= rd_next;
            pslverr <= err_next & psel & ~penable;
            pready  <= rdy_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    ttl_polarity_a: assert property (##1 arcTtl == $past(alarmVec ^ ~polVec))
        else $error("arc output polarity mismatch");
    oc_polarity_a: assert property (##1 ocOn == $past(alarmVec ^ ~polVec))
        else $error("open collector polarity mismatch");
    thresh_trip_a: assert property (booted_reg && pdMv[0] >= thr_reg |=> alarmVec[0])
        else $error("channel did not trip at threshold");
    group_or_a: assert property (booted_reg && !grp_reg[0].andPairs[0]
                                 && grp_reg[0].members[0] && alarmVec[0]
                                 |=> alarmVec[NUM_CH])
        else $error("OR group missed a member alarm");
    group_and_a: assert property (booted_reg && grp_reg[0].andPairs[0]
                                  && grp_reg[0].members[1:0] == 2'b11
                                  && alarmVec[1:0] == 2'b11 |=> alarmVec[NUM_CH])
        else $error("AND group missed coincident pair");
    reset_or_a: assert property (!booted_reg && bootCnt_reg == '0
                                 |-> grp_reg[0] == GRP_RESET && grp_reg[3] == GRP_RESET)
        else $error("groups not OR of all channels after reset");
    sys_ok_a: assert property (!booted_reg || pinS2_reg.powerFail || pinS2_reg.cpuErr
                               || pinS2_reg.cardErr |=> !sysOkClosed)
        else $error("system OK relay closed while unhealthy");
    arc_relay_a: assert property (arcRelayClosed
                                  |-> $past(!booted_reg || |alarmVec || pinS2_reg.cardErr))
        else $error("arc relay closed without cause");
    global_ack_a: assert property (globalAck && arcVec == '0 |=> alarmVec == '0)
        else $error("global reset left an alarm active");
    boot_idle_a: assert property ($rose(booted_reg) |-> alarmVec == '0 ##1 ready)
        else $error("boot ended with alarms or not ready");
    power_fail_a: assert property (pinS2_reg.powerFail |=> pfOcOn == '1)
        else $error("power failure output not driven");
endmodule

// *** tb/aac_remote_model.sv ***
/*
 * Remote control party and RF interlock on the far side of the alarm logic.
 * Assumes one-cycle command strobes from the bench on clk.
 */
module aac_remote_model (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic doTest,
    input  wire logic doReset,
    input  wire logic arcLine,
    output logic      remoteTest,
    output logic      remoteReset,
    output logic      rfOn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] testCnt;
    logic [2:0] resetCnt;
    // Requests stand four cycles so the pin synchroniser cannot miss them
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            testCnt  <= 3'h0;
            resetCnt <= 3'h0;
        end else begin
            testCnt  <= doTest ? 3'h4 : (testCnt == 3'h0 ? 3'h0 : testCnt - 3'h1);
            resetCnt <= doReset ? 3'h4 : (resetCnt == 3'h0 ? 3'h0 : resetCnt - 3'h1);
        end
    end
    assign remoteTest  = testCnt != 3'h0;
    assign remoteReset = resetCnt != 3'h0;
    // RF may run only while the inverted-default line is high
    assign rfOn = arcLine;
endmodule

// *** tb/testbench.sv ***
/*
 * Self-checking bench: APB master, transfer scoreboard and alarm scenarios.
 * Assumes aac_pkg and the remote control model are compiled before it.
 */
module testbench
    import aac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 5;
    localparam int BT = 20;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, kpWe, kpGrpWe, kpPol, kpAuto;
    logic rTest, rReset, rfOn, doTest, doReset, sysOk, arcRel, ready;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [NUM_CH-1:0][MV_W-1:0] pdMv;
    logic [NUM_CELL-1:0] arcTtl, ocOn, pfOcOn;
    logic [23:0] push;
    logic [IDX_W-1:0] kpIndex;
    logic [1:0] kpGrpIdx;
    aac_grp_s kpGrp;
    logic [32:0] notes[$];
    int badCount, compares, cyc, seed;

    aac_alarm_logic #(.TICK_CNT(TK), .BOOT_CNT(BT)) i_aac_alarm_logic (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pdMv(pdMv), .btnPin(push[19:0]),
        .pins({push[23:20], rTest, rReset}), .kpWe(kpWe), .kpIndex(kpIndex),
        .kpPolNormal(kpPol), .kpAutoEn(kpAuto), .kpGrpWe(kpGrpWe), .kpGrpIdx(kpGrpIdx),
        .kpGrp(kpGrp), .arcTtl(arcTtl), .ocOn(ocOn), .pfOcOn(pfOcOn),
        .sysOkClosed(sysOk), .arcRelayClosed(arcRel), .ready(ready)
    );
    aac_remote_model i_aac_remote_model (
        .clk(clk), .rstn(rstn), .doTest(doTest), .doReset(doReset), .arcLine(arcTtl[16]),
        .remoteTest(rTest), .remoteReset(rReset), .rfOn(rfOn)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic wrapUp;
        $display("compares=%0d badCount=%0d", compares, badCount);
        if (badCount == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        compares++;
        if (g !== e) begin
            badCount++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic settle;
        repeat (8) @(posedge clk);
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [32:0] e);
        notes.push_back(e);
        @(posedge clk);
        psel   <= 1'b1;
        paddr  <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the bench timeout may end a wait for the slave
        do @(posedge clk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 33'h0);
        settle();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0, {1'b0, e});
    endtask
    task automatic hit(input int b);
        push[b] <= 1'b1;
        repeat (4) @(posedge clk);
        push[b] <= 1'b0;
        settle();
    endtask

    // Scoreboard: each completed transfer is matched to the oldest note
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && notes.size() > 0)
            chk("apb", notes.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            badCount++;
            wrapUp();
        end
    end

    initial begin
        seed = 4;
        {psel, penable, pwrite, kpWe, kpGrpWe, kpPol, kpAuto, doTest, doReset} = '0;
        {paddr, pwdata, pdMv, push, kpIndex, kpGrpIdx, kpGrp} = '0;
        rstn = 1'b0;
        repeat (12) @(posedge clk);
        chk("arcTtl", 33'hFFFFF, arcTtl);
        chk("relays", 33'h2, {sysOk, arcRel, ready});
        rstn <= 1'b1;
        repeat (BT + 4) @(posedge clk);
        chk("relays", 33'h5, {sysOk, arcRel, ready});
        chk("ocOn", 33'hFFFFF, ocOn);
        rd(OFS_THRESH, 32'h14);
        rd(OFS_CFG, 32'h0001_0000);
        for (int g = 0; g < NUM_GRP; g++)
            rd(OFS_GRP + 8'(4 * g), 32'hFFFF);
        apb(8'h40, 1'b0, 32'h0, {1'b1, 32'h0});
        // Quiet channels carry noise just under the default threshold
        for (int i = 0; i < NUM_CH; i++)
            pdMv[i] <= 10'($unsigned($random(seed)) % 20);
        settle();
        rd(OFS_STATUS, 32'h0010_0000);
        pdMv[3] <= 10'h014;
        settle();
        chk("arcTtl", 33'h0FFF7, arcTtl);
        chk("relays", 33'h7, {sysOk, arcRel, ready});
        pdMv[3] <= 10'h000;
        settle();
        rd(OFS_STATUS, 32'h001F_0008);
        wr(OFS_ACK, 32'h8);
        rd(OFS_STATUS, 32'h001F_0000);
        hit(20);
        rd(OFS_STATUS, 32'h0010_0000);
        kpIndex <= 5'h05;
        kpPol   <= 1'b1;
        kpWe    <= 1'b1;
        @(posedge clk);
        kpWe <= 1'b0;
        settle();
        chk("arcTtl", 33'hFFFDF, arcTtl);
        pdMv[5] <= 10'h1F4;
        settle();
        chk("ocOn", 33'h0FFFF, ocOn);
        pdMv[5] <= 10'h000;
        wr(OFS_ACK, 32'h20);
        doReset <= 1'b1;
        @(posedge clk);
        doReset <= 1'b0;
        settle();
        chk("arcTtl", 33'hFFFDF, arcTtl);
        wr(OFS_SEL, 32'h2);
        wr(OFS_CFG, 32'h0003_0002);
        rd(OFS_CFG, 32'h0003_0002);
        pdMv[2] <= 10'h100;
        repeat (3) @(posedge clk);
        pdMv[2] <= 10'h000;
        settle();
        chk("arcTtl", 33'h0FFDB, arcTtl);
        repeat (20) @(posedge clk);
        chk("arcTtl", 33'h0FFDF, arcTtl);
        hit(20);
        wr(OFS_SEL, 32'd17);
        wr(OFS_CFG, 32'h0001_0002);
        kpGrpIdx <= 2'h1;
        kpGrp    <= '{andPairs: 8'h01, members: 16'h0003};
        kpGrpWe  <= 1'b1;
        @(posedge clk);
        kpGrpWe <= 1'b0;
        rd(OFS_GRP + 8'h04, 32'h0001_0003);
        pdMv[0] <= 10'h050;
        settle();
        rd(OFS_STATUS, 32'h001D_0001);
        pdMv[1] <= 10'h050;
        settle();
        rd(OFS_STATUS, 32'h001F_0003);
        pdMv[0] <= 10'h000;
        pdMv[1] <= 10'h000;
        hit(20);
        hit(20);
        hit(7);
        chk("arcTtl", 33'h2FF5F, arcTtl);
        pdMv[7] <= 10'h030;
        hit(7);
        chk("arcTtl", 33'h2FF5F, arcTtl);
        pdMv[7] <= 10'h000;
        hit(7);
        chk("arcTtl", 33'h2FFDF, arcTtl);
        wr(OFS_ACK, 32'h8000_0000);
        rd(OFS_STATUS, 32'h0010_0000);
        push[21] <= 1'b1;
        settle();
        chk("relays", 33'h3, {sysOk, arcRel, ready});
        push[21] <= 1'b0;
        push[23] <= 1'b1;
        settle();
        chk("relays", 33'h1, {sysOk, arcRel, ready});
        chk("pfOcOn", 33'hFFFFF, pfOcOn);
        push[23] <= 1'b0;
        doTest <= 1'b1;
        @(posedge clk);
        doTest <= 1'b0;
        settle();
        rd(OFS_STATUS, 32'h001F_FFFF);
        chk("rfOn", 33'h0, rfOn);
        wrapUp();
    end
endmodule
